//--- logic/strap_sample_led_pins.sv
// Dual-use strap / status LED pins with reset-time address latching.
// Assumes indication inputs are synchronous to core_clk and strap pins are
// asynchronous; the board pulls each pin through an LED and resistor.
// Assumes the pad cell drives pin_out while pin_oe is high and otherwise
// lets the pull resistor set the level seen on pin_in.
//
// Summary of operation
// - Pins stay inputs during hardware reset; levels are latched at release.
// - Once the straps are latched every pin drives a status LED.
// - Software reset neither resamples the straps nor releases the pins.
// - An asserted output drives the complement of its latched strap.
// - A strap sampled low gives address bit zero, high gives one.
// - The activity pin is address bit 0, then shows receive or transmit.
// - The collision pin is address bit 1, then shows detected collisions.
// - Each collision holds the collision indication for about 70 ms.
// - The link pin is address bit 2, then shows a valid link.
// - The transmit pin is address bit 3, then shows transmit activity.
// - The receive pin is address bit 4, then shows receive activity.
`timescale 1ns/1ps
module strap_sample_led_pins #(
    parameter int unsigned COL_HOLD_CYCLES =
        strap_led_pkg::COL_STRETCH_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic soft_reset,
    input wire logic rx_active,
    input wire logic tx_active,
    input wire logic collision,
    input wire logic link_valid,
    input wire logic [4:0] pin_in,
    output logic [4:0] pin_out,
    output logic [4:0] pin_oe,
    output logic [4:0] strap_mgmt_address,
    output logic straps_valid
);
    typedef enum logic [2:0] {
        ST_RESET = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_DRIVE = 3'b100
    } phase_t;

    phase_t phase_reg;
    phase_t phase_next;
    logic sample_now;
    logic drive_now;
    logic pins_driven;

    logic col_stretched;
    logic act_lit;
    logic col_lit;
    logic link_lit;
    logic tx_lit;
    logic rx_lit;
    logic [4:0] status;
    logic unused_soft_reset;

    // The synchroniser clocks through reset, so it holds real pin levels at
    // release; the latch loads on the second edge, as ST_SAMPLE ends.
    always_comb
    begin
        case (phase_reg)
            ST_RESET:
            begin
                phase_next = ST_SAMPLE;
            end
            ST_SAMPLE:
            begin
                phase_next = ST_DRIVE;
            end
            ST_DRIVE:
            begin
                phase_next = ST_DRIVE;
            end
            default:
            begin
                // A corrupted code restarts the sequence rather than hang.
                phase_next = ST_RESET;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_reg <= ST_RESET;
        end
        else
        begin
            phase_reg <= phase_next;
        end
    end

    assign sample_now = (phase_reg == ST_SAMPLE);
    assign drive_now = (phase_reg == ST_DRIVE);
    // Soft reset takes no part here: once driven, the pins stay driven.
    assign pins_driven = sample_now | drive_now;

    pulse_stretcher #(
        .HOLD_CYCLES(COL_HOLD_CYCLES)
    ) u_col_stretch (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .trigger(collision),
        .stretched(col_stretched)
    );

    assign act_lit = rx_active | tx_active;
    assign col_lit = col_stretched;
    assign link_lit = link_valid;
    assign tx_lit = tx_active;
    assign rx_lit = rx_active;

    assign status[strap_led_pkg::PIN_ACTIVITY] = act_lit;
    assign status[strap_led_pkg::PIN_COLLISION] = col_lit;
    assign status[strap_led_pkg::PIN_LINK] = link_lit;
    assign status[strap_led_pkg::PIN_TRANSMIT] = tx_lit;
    assign status[strap_led_pkg::PIN_RECEIVE] = rx_lit;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            straps_valid <= 1'b0;
        end
        else if (sample_now)
        begin
            straps_valid <= 1'b1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < strap_led_pkg::NUM_PINS; i++)
        begin : g_pin
            logic sync1_reg;
            logic sync2_reg;
            logic addr_reg;
            logic oe_reg;
            logic out_reg;
            logic out_next;
            logic lit;
            logic lit_level;
            logic dark_level;

            // No reset on the synchroniser: the pads are inputs all
            // through reset, so the pair holds settled levels at release.
            always_ff @(posedge core_clk)
            begin
                sync1_reg <= pin_in[i];
            end

            always_ff @(posedge core_clk)
            begin
                sync2_reg <= sync1_reg;
            end

            // Only rst_n reloads the address; a software reset cannot.
            always_ff @(posedge core_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    addr_reg <= strap_led_pkg::ADDR_RESET[i];
                end
                else if (sample_now)
                begin
                    addr_reg <= sync2_reg;
                end
            end

            always_ff @(posedge core_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    oe_reg <= 1'b0;
                end
                else
                begin
                    oe_reg <= pins_driven;
                end
            end

            // The dark level equals the strap, so the pull resistor and
            // the driver agree whenever the LED is off.
            assign lit = status[i];
            assign lit_level = ~addr_reg;
            assign dark_level = addr_reg;
            // At the latch edge the pin repeats its strap: LED stays dark.
            assign out_next = sample_now ? sync2_reg :
                (lit ? lit_level : dark_level);

            always_ff @(posedge core_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    out_reg <= 1'b0;
                end
                else if (pins_driven)
                begin
                    out_reg <= out_next;
                end
            end

            assign strap_mgmt_address[i] = addr_reg;
            assign pin_oe[i] = oe_reg;
            assign pin_out[i] = out_reg;
        end
    endgenerate

    // The soft_reset port exists so integration shows it is ignored.
    assign unused_soft_reset = soft_reset;
endmodule : strap_sample_led_pins

//--- logic/strap_led_pkg.sv
// Constants for the strap-sampled address and status LED pin block.
// Assumes a single 10 MHz core clock and an active-low asynchronous reset.
package strap_led_pkg;
    localparam int NUM_PINS = 5;
    localparam int PIN_ACTIVITY = 0;
    localparam int PIN_COLLISION = 1;
    localparam int PIN_LINK = 2;
    localparam int PIN_TRANSMIT = 3;
    localparam int PIN_RECEIVE = 4;
    localparam logic [4:0] ADDR_RESET = 5'h00;
    localparam int CLK_PERIOD_NS = 100;
    localparam int COL_STRETCH_MS = 70;
    localparam int COL_STRETCH_CYCLES =
        (COL_STRETCH_MS * 1000000) / CLK_PERIOD_NS;
    localparam int COL_CNT_W = 20;
endpackage : strap_led_pkg

//--- logic/pulse_stretcher.sv
// Stretches a one-cycle event into a level held for a fixed cycle count.
// Assumes the event input is already synchronous to core_clk.
`timescale 1ns/1ps
module pulse_stretcher #(
    parameter int unsigned HOLD_CYCLES = strap_led_pkg::COL_STRETCH_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic trigger,
    output logic stretched
);
    logic [strap_led_pkg::COL_CNT_W-1:0] count_reg;
    logic [strap_led_pkg::COL_CNT_W-1:0] count_next;
    localparam logic [strap_led_pkg::COL_CNT_W-1:0] HOLD =
        strap_led_pkg::COL_CNT_W'(HOLD_CYCLES);

    // A new collision restarts the full hold, so bursts keep the LED lit.
    assign count_next = trigger ? HOLD :
        (count_reg != '0) ? count_reg - 1'b1 : count_reg;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_reg <= '0;
            stretched <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            stretched <= trigger || (count_next != '0);
        end
    end
endmodule : pulse_stretcher

//--- test/board_pulls.sv
// Board pull resistors with series LEDs on the five dual-use pins.
// Assumes pin_oe is high while the block drives a pin.
`timescale 1ns/1ps
module board_pulls (
    input wire logic [4:0] strap,
    input wire logic [4:0] pin_out,
    input wire logic [4:0] pin_oe,
    output logic [4:0] pin_in
);
    // A released pin reads its pull level, never the last value driven.
    assign pin_in = pin_oe & pin_out | ~pin_oe & strap;
endmodule : board_pulls

//--- test/strap_led_monitor.sv
// Port checker for the strap latch and status LED pins.
// Assumes status inputs are synchronous to core_clk.
`timescale 1ns/1ps
module strap_led_monitor #(
    parameter int unsigned COL_HOLD_CYCLES = 20
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic soft_reset,
    input wire logic rx_active,
    input wire logic tx_active,
    input wire logic collision,
    input wire logic link_valid,
    input wire logic straps_valid,
    input wire logic [4:0] pin_in,
    input wire logic [4:0] pin_out,
    input wire logic [4:0] pin_oe,
    input wire logic [4:0] strap_mgmt_address
);
    wire logic [4:0] led = pin_out ^ strap_mgmt_address;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_run; straps_valid && $past(straps_valid); endsequence
    a_pins_out: assert property (pin_oe == {5{straps_valid}})
        else $error("enables");
    a_strap_latch: assert property ($rose(straps_valid) |-> !led &&
        strap_mgmt_address == $past(pin_in)) else $error("latch");
    a_addr_hold: assert property (straps_valid |=>
        $stable(strap_mgmt_address)) else $error("address");
    a_act_led: assert property (s_run |->
        led[0] == ($past(rx_active) | $past(tx_active))) else $error("act");
    a_link_led: assert property (s_run |->
        led[2] == $past(link_valid)) else $error("link");
    a_xfer_leds: assert property (s_run |->
        led[4:3] == {$past(rx_active), $past(tx_active)}) else $error("xfer");
    a_col_start: assert property (straps_valid && collision |->
        ##2 led[1]) else $error("collision");
    a_col_hold: assert property (straps_valid && $fell(collision) |->
        ##1 led[1] [*8]) else $error("stretch");
endmodule : strap_led_monitor
bind strap_sample_led_pins strap_led_monitor #(
    .COL_HOLD_CYCLES(COL_HOLD_CYCLES)
) i_mon (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .soft_reset(soft_reset),
    .rx_active(rx_active),
    .tx_active(tx_active),
    .collision(collision),
    .link_valid(link_valid),
    .straps_valid(straps_valid),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .strap_mgmt_address(strap_mgmt_address)
);

//--- test/test_strap_sample_led_pins.sv
// Bench with a cycle model of the latched address and LED outputs.
// Assumes board_pulls gives each released pin its strap level.
`timescale 1ns/1ps
module test_strap_sample_led_pins;
    localparam int HOLD = 20;
    logic core_clk = 0;
    logic rst_n;
    logic soft_reset;
    logic rx_active;
    logic tx_active;
    logic collision;
    logic link_valid;
    logic straps_valid;
    logic col_lit;
    logic [4:0] strap;
    logic [4:0] pin_in;
    logic [4:0] pin_out;
    logic [4:0] pin_oe;
    logic [4:0] strap_mgmt_address;
    logic [15:0] e;
    wire logic [15:0] s = {straps_valid, strap_mgmt_address, pin_oe, pin_out};
    int miscompares = 0;
    int comparisons = 0;
    int seed = 32'h14DB;
    int gap;
    always #50 core_clk = ~core_clk;
    strap_sample_led_pins #(
        .COL_HOLD_CYCLES(HOLD)
    ) i_dut (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .soft_reset(soft_reset),
        .rx_active(rx_active),
        .tx_active(tx_active),
        .collision(collision),
        .link_valid(link_valid),
        .pin_in(pin_in),
        .pin_out(pin_out),
        .pin_oe(pin_oe),
        .strap_mgmt_address(strap_mgmt_address),
        .straps_valid(straps_valid)
    );
    board_pulls i_board (
        .strap(strap),
        .pin_out(pin_out),
        .pin_oe(pin_oe),
        .pin_in(pin_in)
    );
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        comparisons++;
        miscompares += int'(seen !== exp);
        if (seen !== exp)
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
    endtask : check
    task automatic summarize(bit hung);
        miscompares += hung;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize
    initial #1000000 summarize(1);
    initial
    begin
        for (int r = 0; r < 4; r++)
        begin
            rst_n = 0;
            {rx_active, tx_active, collision} = 3'h0;
            {link_valid, soft_reset} = 2'h0;
            strap = r < 2 ? {5{r[0]}} : 5'($random(seed));
            gap = 99;
            repeat (20) @(negedge core_clk);
            check("reset", s, 16'h0000);
            rst_n = 1;
            @(negedge core_clk);
            check("sync", s, 16'h0000);
            @(negedge core_clk);
            check("latch", s, {1'b1, strap, 5'h1F, strap});
            @(negedge core_clk);
            check("dark", s, {1'b1, strap, 5'h1F, strap});
            repeat (150)
            begin
                {rx_active, tx_active} = 2'($random(seed));
                {link_valid, soft_reset} = 2'($random(seed));
                collision = 4'($random(seed)) == 4'h0;
                col_lit = gap < HOLD;
                gap = collision ? 0 : gap + 1;
                e = {1'b1, strap, 5'h1F, strap ^ {rx_active, tx_active,
                    link_valid, col_lit, rx_active | tx_active}};
                @(negedge core_clk);
                check("pins", s, e);
            end
        end
        summarize(0);
    end
endmodule : test_strap_sample_led_pins
